// ---- hw/mne_pkg.sv ----
// constants, types and state layout of the multiply and negate execution datapath
// Overview of operation
// (RULE1) multiply-by-file forms the full 16-bit unsigned product of the accumulator and the addressed file register.
// (RULE2) the upper product byte goes to the product high register and the lower byte to the product low register.
// (RULE3) multiply-by-file changes neither the accumulator nor the file register, only the product pair.
// (RULE4) neither multiply touches any status flag, not even zero on a zero product.
// (RULE5) multiply-by-file is decoded from 0000 001a ffff ffff with bit 8 as access select and the low byte as address.
// (RULE6) access select 0 targets the access bank regardless of the bank select register, 1 uses that register.
// (RULE7) the file address covers 0 to 255 inside the chosen bank for multiply-by-file and negate.
// (RULE8) each multiply takes one instruction cycle: decode, operand read, process, product write in phases one to four.
// (RULE9) multiply-by-literal takes its immediate from the instruction word in phase two and writes both product bytes in phase four.
// (RULE10) negate inverts the file register, adds one and writes the result back to the same location.
// (RULE11) negate updates the negative, signed range, carry, nibble carry and zero flags from its result.
// (RULE12) negate is decoded from 0110 110a ffff ffff with bit 8 as access select and the low byte as address.
// (RULE13) multiply-by-literal is decoded from prefix 0000 1101 with the literal in the low byte.
// (RULE14) the 8x8 product settles within phase three so phase four writes it without a stall.
package mne_pkg;

   // ****************************************
   // opcode patterns
   // ****************************************
   localparam logic [6:0] OPC_MUL_FILE  = 7'h01;
   localparam logic [6:0] OPC_NEG_FILE  = 7'h36;
   localparam logic [7:0] OPC_MUL_LIT   = 8'h0D;
   localparam int         OPC_HI7       = 9;
   localparam int         OPC_HI8       = 8;
   localparam int         ACCESS_BIT    = 8;

   // ****************************************
   // access bank split, plain defaults
   // ****************************************
   localparam int         BANK_W        = 4;
   localparam logic [7:0] ACCESS_SPLIT  = 8'h80;
   localparam logic [3:0] ACCESS_LO     = 4'h0;
   localparam logic [3:0] ACCESS_HI     = 4'hF;

   localparam logic [7:0] BYTE_ZERO     = 8'h00;
   localparam logic [8:0] NEG_ONE9      = 9'h001;
   localparam logic [4:0] NEG_ONE5      = 5'h01;
   localparam logic [15:0] PROD_ZERO    = 16'h0000;

   typedef enum logic [1:0] {
      OP_NONE    = 2'h0,
      OP_MUL_F   = 2'h1,
      OP_MUL_L   = 2'h2,
      OP_NEG_F   = 2'h3
   } mne_op_t;

   // gray order along idle, q1, q2, q3, q4
   typedef enum logic [2:0] {
      PH_IDLE    = 3'h0,
      PH_Q1      = 3'h1,
      PH_Q2      = 3'h3,
      PH_Q3      = 3'h2,
      PH_Q4      = 3'h6
   } mne_phase_t;

   typedef struct packed {
      logic             neg;
      logic             signedRange;
      logic             carry;
      logic             nibbleCarry;
      logic             zero;
   } mne_flags_t;

   typedef struct packed {
      logic              en;
      logic [BANK_W-1:0] bank;
      logic [7:0]        addr;
   } mne_fileRd_t;

   typedef struct packed {
      logic              en;
      logic [BANK_W-1:0] bank;
      logic [7:0]        addr;
      logic [7:0]        data;
   } mne_fileWr_t;

   typedef struct packed {
      mne_phase_t        phase;
      mne_op_t           op;
      logic              accessSel;
      logic [7:0]        lowByte;
      logic [7:0]        acc;
      logic [7:0]        operand;
      logic [15:0]       product;
      logic [7:0]        prodHigh;
      logic [7:0]        prodLow;
      mne_fileRd_t       rd;
      mne_fileWr_t       wr;
      logic              flagWr;
      mne_flags_t        flags;
      logic              done;
      logic              busy;
   } mne_state_t;

   function automatic mne_op_t decodeOp(input logic [15:0] w);
      mne_op_t o;
      o = OP_NONE;
      if (w[15:OPC_HI7] == OPC_MUL_FILE) begin
         o = OP_MUL_F;
      end else if (w[15:OPC_HI7] == OPC_NEG_FILE) begin
         o = OP_NEG_F;
      end else if (w[15:OPC_HI8] == OPC_MUL_LIT) begin
         o = OP_MUL_L;
      end
      return o;
   endfunction

   function automatic logic isMul(input mne_op_t o);
      return (o == OP_MUL_F) || (o == OP_MUL_L);
   endfunction

endpackage

// ---- hw/mne_mult8.sv ----
// unsigned 8x8 array multiplier, purely combinational
module mne_mult8
   import mne_pkg::*;
(
   input  wire logic [7:0]  multA,
   input  wire logic [7:0]  multB,
   output logic      [15:0] product
);

   // one level of logic per partial product, short enough for one 40 ns phase
   always_comb begin
      product = PROD_ZERO;
      for (int i = 0; i < 8; i++) begin
         if (multB[i]) begin
            product = product + (16'(multA) << i);
         end
      end
   end

endmodule

// ---- hw/mne_exec_top.sv ----
// four-phase execution of multiply-by-file, multiply-by-literal and negate-file
module mne_exec_top
   import mne_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              instrStart,
   input  wire logic [15:0]       instrWord,
   input  wire logic [7:0]        accValue,
   input  wire logic [BANK_W-1:0] bankSelect,
   input  wire logic [7:0]        fileRdData,
   output mne_fileRd_t            fileRd,
   output mne_fileWr_t            fileWr,
   output logic [7:0]             productHigh,
   output logic [7:0]             productLow,
   output logic                   flagWr,
   output mne_flags_t             flags,
   output logic                   done,
   output logic                   busy
);

   mne_state_t  state_r;
   mne_state_t  state_nxt;
   logic [15:0] multOut;
   logic [8:0]  negSum;
   logic [4:0]  nibSum;
   mne_op_t     newOp;

   // ****************************************
   // multiplier
   // ****************************************
   mne_mult8 u_mult (
      .multA   (state_r.acc),
      .multB   (state_r.operand),
      .product (multOut)
   );

   assign negSum = {1'b0, ~state_r.operand} + NEG_ONE9;
   assign nibSum = {1'b0, ~state_r.operand[3:0]} + NEG_ONE5;
   assign newOp  = decodeOp(instrWord);

   // ****************************************
   // phase sequencing
   // ****************************************
   always_comb begin
      state_nxt        = state_r;
      state_nxt.done   = 1'b0;
      state_nxt.flagWr = 1'b0;
      state_nxt.rd.en  = 1'b0;
      state_nxt.wr.en  = 1'b0;
      unique case (state_r.phase)
         PH_IDLE, PH_Q4: begin
            state_nxt.phase = PH_IDLE;
            state_nxt.busy  = 1'b0;
            if (state_r.phase == PH_Q4 && isMul(state_r.op)) begin
               state_nxt.prodHigh = state_r.product[15:8]; // RULE2 RULE9
               state_nxt.prodLow  = state_r.product[7:0]; // RULE2
            end
            // unknown opcodes are never taken, so the block stays idle for them
            if (instrStart && newOp != OP_NONE) begin // RULE5 RULE12 RULE13
               state_nxt.phase     = PH_Q1;
               state_nxt.busy      = 1'b1;
               state_nxt.op        = newOp;
               state_nxt.accessSel = instrWord[ACCESS_BIT];
               state_nxt.lowByte   = instrWord[7:0]; // RULE7
            end
         end
         PH_Q1: begin
            state_nxt.phase = PH_Q2;
            if (state_r.op != OP_MUL_L) begin
               state_nxt.rd.en   = 1'b1;
               state_nxt.rd.addr = state_r.lowByte; // RULE7
               if (state_r.accessSel) begin
                  state_nxt.rd.bank = bankSelect; // RULE6
               end else if (state_r.lowByte < ACCESS_SPLIT) begin
                  state_nxt.rd.bank = ACCESS_LO; // RULE6
               end else begin
                  state_nxt.rd.bank = ACCESS_HI; // RULE6
               end
            end
         end
         PH_Q2: begin
            state_nxt.phase = PH_Q3;
            state_nxt.acc   = accValue;
            if (state_r.op == OP_MUL_L) begin
               state_nxt.operand = state_r.lowByte; // RULE9
            end else begin
               state_nxt.operand = fileRdData; // RULE8
            end
         end
         PH_Q3: begin
            state_nxt.phase = PH_Q4;
            if (isMul(state_r.op)) begin // RULE1 RULE3 RULE4
               state_nxt.product = multOut; // RULE1 RULE14
            end else begin
               // multiply leaves file and flags alone
               state_nxt.wr.en             = 1'b1; // RULE10
               state_nxt.wr.bank           = state_r.rd.bank;
               state_nxt.wr.addr           = state_r.rd.addr;
               state_nxt.wr.data           = negSum[7:0]; // RULE10
               state_nxt.flagWr            = 1'b1; // RULE11
               state_nxt.flags.neg         = negSum[7]; // RULE11
               state_nxt.flags.zero        = (negSum[7:0] == BYTE_ZERO); // RULE11
               state_nxt.flags.carry       = negSum[8]; // RULE11
               state_nxt.flags.nibbleCarry = nibSum[4]; // RULE11
               // range error only when the most negative byte negates onto itself
               state_nxt.flags.signedRange = state_r.operand[7] & negSum[7]; // RULE11
            end
            state_nxt.done = 1'b1; // RULE8
         end
         default: begin
            state_nxt.phase = PH_IDLE;
            state_nxt.busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign fileRd      = state_r.rd;
   assign fileWr      = state_r.wr;
   assign productHigh = state_r.prodHigh;
   assign productLow  = state_r.prodLow;
   assign flagWr      = state_r.flagWr;
   assign flags       = state_r.flags;
   assign done        = state_r.done;
   assign busy        = state_r.busy;

   // ****************************************
   // assertions
   // ****************************************
   a_product_pair: assert property (@(posedge core_clk) disable iff (rst) // RULE1
      (state_r.phase == PH_Q4 && isMul(state_r.op)) |=>
      ({productHigh, productLow} == 16'($past(state_r.acc)) * 16'($past(state_r.operand))))
      else $error("product pair does not match operands");

   a_product_hold: assert property (@(posedge core_clk) disable iff (rst) // RULE2
      (state_r.phase != PH_Q4) |=> $stable({productHigh, productLow}))
      else $error("product pair changed outside phase four");

   a_mul_no_write: assert property (@(posedge core_clk) disable iff (rst) // RULE3
      (isMul(state_r.op) && state_r.busy) |-> !fileWr.en)
      else $error("multiply wrote the file");

   a_mul_no_flags: assert property (@(posedge core_clk) disable iff (rst) // RULE4
      (isMul(state_r.op) && state_r.busy) |-> !flagWr)
      else $error("multiply touched flags");

   a_phase_walk: assert property (@(posedge core_clk) disable iff (rst) // RULE8
      (state_r.phase == PH_Q1) |=> (state_r.phase == PH_Q2) ##1 (state_r.phase == PH_Q3)
      ##1 (state_r.phase == PH_Q4 && done))
      else $error("instruction did not take four phases");

   a_read_phase: assert property (@(posedge core_clk) disable iff (rst) // RULE9
      fileRd.en |-> (state_r.phase == PH_Q2 && state_r.op != OP_MUL_L))
      else $error("file read outside phase two");

   a_access_bank: assert property (@(posedge core_clk) disable iff (rst) // RULE6
      (fileRd.en && !state_r.accessSel) |->
      (fileRd.bank == ((fileRd.addr < ACCESS_SPLIT) ? ACCESS_LO : ACCESS_HI)))
      else $error("access bank not used");

   a_neg_result: assert property (@(posedge core_clk) disable iff (rst) // RULE10
      fileWr.en |-> (fileWr.data == 8'(~state_r.operand + 8'h01)) && (fileWr.addr == fileRd.addr)
      && (state_r.phase == PH_Q4))
      else $error("negate result wrong");

   a_neg_flags: assert property (@(posedge core_clk) disable iff (rst) // RULE11
      flagWr |-> (flags.zero == (fileWr.data == BYTE_ZERO)) && (flags.neg == fileWr.data[7])
      && (flags.carry == (state_r.operand == BYTE_ZERO)))
      else $error("negate flags wrong");

   a_neg_range: assert property (@(posedge core_clk) disable iff (rst) // RULE11
      flagWr |-> (flags.signedRange == (state_r.operand == 8'h80))
      && (flags.nibbleCarry == (state_r.operand[3:0] == 4'h0)))
      else $error("negate range or nibble flag wrong");

   a_bank_select: assert property (@(posedge core_clk) disable iff (rst) // RULE6
      (fileRd.en && state_r.accessSel) |-> (fileRd.bank == $past(bankSelect)))
      else $error("bank select register not used");

   a_read_addr: assert property (@(posedge core_clk) disable iff (rst) // RULE7
      (state_r.phase == PH_Q1 && state_r.op != OP_MUL_L) |=> (fileRd.addr == $past(state_r.lowByte)))
      else $error("file address not taken from the word");

   a_literal_operand: assert property (@(posedge core_clk) disable iff (rst) // RULE9
      (state_r.phase == PH_Q3 && state_r.op == OP_MUL_L) |-> (state_r.operand == state_r.lowByte))
      else $error("literal operand not taken from the word");

   a_lit_decode: assert property (@(posedge core_clk) disable iff (rst) // RULE13
      (instrStart && state_r.phase == PH_IDLE && instrWord[15:OPC_HI8] == OPC_MUL_LIT)
      |=> (state_r.op == OP_MUL_L && busy))
      else $error("literal multiply not taken");

   a_refuse_unknown: assert property (@(posedge core_clk) disable iff (rst) // RULE5
      (instrStart && state_r.phase == PH_IDLE && instrWord[15:OPC_HI7] != OPC_MUL_FILE
      && instrWord[15:OPC_HI7] != OPC_NEG_FILE && instrWord[15:OPC_HI8] != OPC_MUL_LIT)
      |=> (state_r.phase == PH_IDLE && !busy))
      else $error("unknown opcode was taken");

   a_done_pulse: assert property (@(posedge core_clk) disable iff (rst) // RULE8
      done |=> !done)
      else $error("done stood longer than one cycle");

   c_mul_file: cover property (@(posedge core_clk) disable iff (rst)
      state_r.phase == PH_Q4 && state_r.op == OP_MUL_F);
   c_mul_lit: cover property (@(posedge core_clk) disable iff (rst)
      state_r.phase == PH_Q4 && state_r.op == OP_MUL_L);
   c_negate: cover property (@(posedge core_clk) disable iff (rst) flagWr && flags.signedRange);
   c_back_to_back: cover property (@(posedge core_clk) disable iff (rst)
      state_r.phase == PH_Q4 ##1 state_r.phase == PH_Q1);
   c_refused: cover property (@(posedge core_clk) disable iff (rst)
      instrStart && state_r.phase == PH_IDLE && newOp == OP_NONE);

endmodule

// ---- verification/mne_regfile_model.sv ----
// register file model standing on the far side of the execution datapath
module mne_regfile_model
   import mne_pkg::*;
(
   input  wire logic        core_clk,
   input  wire mne_fileRd_t fileRd,
   input  wire mne_fileWr_t fileWr,
   output logic [7:0]       fileRdData
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // storage, 16 banks of 256 bytes
   // ****************************************
   logic [7:0] mem [0:4095];
   logic       idleTog;

   initial idleTog = 1'b0;

   // plain always so the bench may preload bytes between instructions
   always @(posedge core_clk) begin
      idleTog <= ~idleTog;
      if (fileWr.en === 1'b1) begin
         mem[{fileWr.bank, fileWr.addr}] <= fileWr.data;
      end
   end

   // unselected read shows a toggling pattern, never the last byte
   assign fileRdData = (fileRd.en === 1'b1) ? mem[{fileRd.bank, fileRd.addr}] : {8{idleTog}};
endmodule

// ---- verification/multiply_negate_exec_tb.sv ----
// self-checking bench of the multiply and negate execution datapath
module multiply_negate_exec_tb;
   import mne_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic              core_clk, rst, instrStart;
   logic [15:0]       instrWord;
   logic [7:0]        accValue, fileRdData, productHigh, productLow;
   logic [BANK_W-1:0] bankSelect;
   mne_fileRd_t       fileRd;
   mne_fileWr_t       fileWr;
   mne_flags_t        flags;
   logic              flagWr, done, busy;
   int                errorCnt, testsRun, cycles;

   mne_exec_top mne_exec_top_inst (.core_clk(core_clk), .rst(rst), .instrStart(instrStart),
      .instrWord(instrWord), .accValue(accValue), .bankSelect(bankSelect), .fileRdData(fileRdData),
      .fileRd(fileRd), .fileWr(fileWr), .productHigh(productHigh), .productLow(productLow),
      .flagWr(flagWr), .flags(flags), .done(done), .busy(busy));
   mne_regfile_model mne_regfile_model_inst (.core_clk(core_clk), .fileRd(fileRd), .fileWr(fileWr),
      .fileRdData(fileRdData));

   always #20 core_clk = ~core_clk;

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic results();
      $display("checks %0d mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
      testsRun++;
      if (got !== expv) begin
         $display("Error %s expected %h seen %h", what, expv, got);
         errorCnt++;
      end
   endtask

   // offered at a falling edge, returns at the falling edge of the done cycle
   task automatic runOp(input logic [15:0] w, input logic [7:0] acc, input logic [3:0] bsel, input logic fileOp);
      int n;
      instrWord = w;
      accValue = acc;
      bankSelect = bsel;
      instrStart = 1'b1;
      @(negedge core_clk);
      instrStart = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < 10) begin
         if (n == 2) chk("read strobe", {15'h0000, fileOp}, {15'h0000, fileRd.en});
         if (n == 2) chk("busy mid op", 16'h0001, {15'h0000, busy});
         @(negedge core_clk);
         n++;
      end
      chk("cycles to done", 16'h0004, 16'(n));
   endtask

   task automatic mulFile(input logic a, input logic [7:0] addr, input logic [3:0] bsel, input logic [3:0] bank,
                          input logic [7:0] val, input logic [7:0] acc);
      mne_flags_t keep;
      keep = flags;
      mne_regfile_model_inst.mem[{bank, addr}] = val;
      runOp({OPC_MUL_FILE, a, addr}, acc, bsel, 1'b1);
      chk("read place", {4'h0, bank, addr}, {4'h0, fileRd.bank, fileRd.addr});
      chk("write strobe", 16'h0000, {15'h0000, fileWr.en});
      chk("flag strobe", 16'h0000, {15'h0000, flagWr});
      @(negedge core_clk);
      chk("file product", 16'(acc) * 16'(val), {productHigh, productLow});
      chk("file kept", {8'h00, val}, {8'h00, mne_regfile_model_inst.mem[{bank, addr}]});
      chk("flags kept", {11'h000, keep}, {11'h000, flags});
      $display("test multiply file %h done", addr);
   endtask

   task automatic negFile(input logic a, input logic [7:0] addr, input logic [3:0] bsel, input logic [3:0] bank,
                          input logic [7:0] val, input logic [7:0] res, input logic [4:0] expFlags);
      mne_regfile_model_inst.mem[{bank, addr}] = val;
      runOp({OPC_NEG_FILE, a, addr}, 8'h5A, bsel, 1'b1);
      chk("write place", {3'h0, 1'b1, bank, addr}, {3'h0, fileWr.en, fileWr.bank, fileWr.addr});
      chk("flag strobe", 16'h0001, {15'h0000, flagWr});
      chk("flags", {11'h000, expFlags}, {11'h000, flags});
      @(negedge core_clk);
      chk("negated byte", {8'h00, res}, {8'h00, mne_regfile_model_inst.mem[{bank, addr}]});
      $display("test negate %h done", val);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic testReset();
      chk("product after reset", 16'h0000, {productHigh, productLow});
      chk("busy after reset", 16'h0000, {15'h0000, busy});
      instrWord = 16'hFFFF;
      instrStart = 1'b1;
      @(negedge core_clk);
      instrStart = 1'b0;
      chk("unknown opcode", 16'h0000, {15'h0000, busy});
      $display("test reset and refusal done");
   endtask

   task automatic testMulLit();
      logic [7:0] accs [3] = '{8'hE2, 8'hFF, 8'h00};
      logic [7:0] lits [3] = '{8'hC4, 8'hFF, 8'h37};
      mne_flags_t keep;
      keep = flags;
      for (int i = 0; i < 3; i++) begin
         runOp({OPC_MUL_LIT, lits[i]}, accs[i], 4'h0, 1'b0);
         chk("flag strobe", 16'h0000, {15'h0000, flagWr});
         @(negedge core_clk);
         chk("literal product", 16'(accs[i]) * 16'(lits[i]), {productHigh, productLow});
         chk("flags kept", {11'h000, keep}, {11'h000, flags});
      end
      $display("test multiply literal done");
   endtask

   task automatic testBackToBack();
      runOp({OPC_MUL_LIT, 8'h10}, 8'h21, 4'h0, 1'b0);
      mne_regfile_model_inst.mem[{4'h2, 8'h44}] = 8'h01;
      runOp({OPC_NEG_FILE, 1'b1, 8'h44}, 8'h00, 4'h2, 1'b1);
      @(negedge core_clk);
      chk("first product", 16'h0210, {productHigh, productLow});
      chk("second result", 16'h00FF, {8'h00, mne_regfile_model_inst.mem[{4'h2, 8'h44}]});
      $display("test back to back done");
   endtask

   task automatic testMidReset();
      instrWord = {OPC_MUL_LIT, 8'h07};
      accValue = 8'h09;
      instrStart = 1'b1;
      @(negedge core_clk);
      instrStart = 1'b0;
      @(negedge core_clk);
      rst = 1'b1;
      @(negedge core_clk);
      rst = 1'b0;
      chk("busy after mid reset", 16'h0000, {15'h0000, busy});
      chk("product after mid reset", 16'h0000, {productHigh, productLow});
      runOp({OPC_MUL_LIT, 8'h03}, 8'h05, 4'h0, 1'b0);
      @(negedge core_clk);
      chk("product after restart", 16'h000F, {productHigh, productLow});
      $display("test reset in flight done");
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         errorCnt++;
         results();
      end
   end

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      instrStart = 1'b0;
      instrWord = 16'h0000;
      accValue = 8'h00;
      bankSelect = 4'h0;
      errorCnt = 0;
      testsRun = 0;
      cycles = 0;
      repeat (17) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      testReset();
      negFile(1'b0, 8'hFF, 4'h3, ACCESS_HI, 8'h3A, 8'hC6, 5'h10);
      negFile(1'b1, 8'h00, 4'h3, 4'h3, 8'h80, 8'h80, 5'h1A);
      negFile(1'b0, 8'h7F, 4'h9, ACCESS_LO, 8'h00, 8'h00, 5'h07);
      testMulLit();
      mulFile(1'b1, 8'h3C, 4'h5, 4'h5, 8'hB5, 8'hC4);
      mulFile(1'b0, 8'h10, 4'h5, ACCESS_LO, 8'hFF, 8'hFF);
      mulFile(1'b0, 8'hFF, 4'h5, ACCESS_HI, 8'h02, 8'h81);
      testBackToBack();
      testMidReset();
      results();
   end
endmodule
